// File: inc/rptac_pkg.sv
// ****************************************************************
// shared constants for the repeater activity and collision core
// ****************************************************************
package rptac_pkg;
    // number of ports: eight twisted-pair plus the aui port
    localparam int TP_PORTS = 8;
    localparam int NET_PORTS = TP_PORTS + 1;
    // index of the aui port within the network port vector
    localparam int AUI_IDX = 8;
    // collision presence pair signal, nominal frequency in mhz
    localparam int CP_FREQ_MHZ = 10;
    // core clock rate in mhz
    localparam int CLK_MHZ = 250;
    // half period of the 10 mhz collision signal, rounded down, in cycles
    localparam int CP_HALF_CYC = CLK_MHZ / (2 * CP_FREQ_MHZ);
    // collision presence is dropped after this many cycles without an edge
    localparam int CP_HOLD_CYC = 4 * CP_HALF_CYC;
    // jam bit time: 100 ns at 10 mbit/s, in cycles
    localparam int JAM_BIT_NS = 100;
    localparam int JAM_BIT_CYC = (JAM_BIT_NS * CLK_MHZ) / 1000;
    // cycles the buffered data keeps repeating after reception ends
    localparam int DRAIN_CYC = 64;
    // default partition thresholds
    localparam int PART_LIMIT = 31;
    localparam int RECONN_LIMIT = 2;
    // reset values
    localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// File: design/rptac_port_guard.sv
`timescale 1ns/1ps
// ****************************************************************
// per-port partition guard: counts collisions, isolates and rejoins
// ****************************************************************
module rptac_port_guard #(
    parameter int PART_LIMIT = rptac_pkg::PART_LIMIT,
    parameter int RECONN_LIMIT = rptac_pkg::RECONN_LIMIT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic coll_end,
    input wire logic clean_end,
    output logic part
);
    // consecutive collision and clean-frame counters
    logic [7:0] coll_cnt, next_coll_cnt;
    logic [7:0] clean_cnt, next_clean_cnt;
    logic next_part;

    // next state of the guard
    always_comb begin
        next_coll_cnt = coll_cnt;
        next_clean_cnt = clean_cnt;
        next_part = part;
        if (coll_end) begin
            // another collided frame
            next_clean_cnt = rptac_pkg::CNT_RST;
            if (coll_cnt < 8'(PART_LIMIT)) begin
                next_coll_cnt = coll_cnt + 8'h01;
            end
            if (coll_cnt + 8'h01 >= 8'(PART_LIMIT)) begin
                next_part = 1'b1;
            end
        end else if (clean_end) begin
            // collision free frame
            next_coll_cnt = rptac_pkg::CNT_RST;
            if (part) begin
                next_clean_cnt = clean_cnt + 8'h01;
                if (clean_cnt + 8'h01 >= 8'(RECONN_LIMIT)) begin
                    next_part = 1'b0;
                    next_clean_cnt = rptac_pkg::CNT_RST;
                end
            end
        end
    end

    // register the guard
    always_ff @(posedge core_clk) begin
        if (reset) begin
            coll_cnt <= rptac_pkg::CNT_RST;
            clean_cnt <= rptac_pkg::CNT_RST;
            part <= 1'b0;
        end else begin
            coll_cnt <= next_coll_cnt;
            clean_cnt <= next_clean_cnt;
            part <= next_part;
        end
    end
endmodule

// File: design/rptac_core.sv
`timescale 1ns/1ps
// Contract
// - active while receiving or draining buffered data
// - during jam, active only while any receives
// - activity request follows active status
// - two or more receivers means collision
// - reception while repeating means collision
// - 10 MHz collision presence means collision
// - jam is alternating ones and zeros
// - network ports are eight tp plus aui
// - excessive collisions partition the port
// - clean traffic reconnects a partitioned port
// - flag receive collision for non-colliding detector
// - last remaining receiver is in receive collision
// - aui transmit collision: presence while transmitting
// - tp transmit collision: receive while transmitting
module rptac_core #(
    parameter int PART_LIMIT = rptac_pkg::PART_LIMIT,
    parameter int RECONN_LIMIT = rptac_pkg::RECONN_LIMIT
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [8:0] port_rx,
    input wire logic collision_presence_pair,
    output logic act_req,
    output logic collision,
    output logic jam_data,
    output logic repeat_tx,
    output logic [8:0] port_tx_en,
    output logic [8:0] rx_coll,
    output logic [8:0] tx_coll,
    output logic [8:0] partitioned
);
    localparam int N = rptac_pkg::NET_PORTS;
    localparam int A = rptac_pkg::AUI_IDX;

    // ****************************************************************
    // input synchronisers
    // ****************************************************************
    logic [N-1:0] rx_s1, rx_s2;
    logic [N-1:0] rx_s3; // last synced value, for end-of-reception edges
    logic cp_s1, cp_s2, cp_s3;
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rx_s1 <= '0;
            rx_s2 <= '0;
            rx_s3 <= '0;
            cp_s1 <= 1'b0;
            cp_s2 <= 1'b0;
            cp_s3 <= 1'b0;
        end else begin
            rx_s1 <= port_rx;
            rx_s2 <= rx_s1;
            rx_s3 <= rx_s2;
            cp_s1 <= collision_presence_pair;
            cp_s2 <= cp_s1;
            cp_s3 <= cp_s2;
        end
    end

    // count of ports receiving; partitioned ports take no part
    function automatic logic [3:0] pop(input logic [N-1:0] v);
        logic [3:0] c;
        c = 4'h0;
        for (int i = 0; i < N; i++) begin
            c = c + {3'b000, v[i]};
        end
        return c;
    endfunction

    // ****************************************************************
    // collision presence detector
    // ****************************************************************
    logic [7:0] cp_cnt, next_cp_cnt;
    logic cp_active, next_cp_active;
    // any edge of the 10 mhz signal retriggers the hold window
    always_comb begin
        next_cp_cnt = cp_cnt;
        next_cp_active = cp_active;
        if (cp_s2 != cp_s3) begin
            next_cp_cnt = 8'(rptac_pkg::CP_HOLD_CYC);
            next_cp_active = 1'b1;
        end else if (cp_cnt != 8'h00) begin
            next_cp_cnt = cp_cnt - 8'h01;
        end else begin
            next_cp_active = 1'b0;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            cp_cnt <= rptac_pkg::CNT_RST;
            cp_active <= 1'b0;
        end else begin
            cp_cnt <= next_cp_cnt;
            cp_active <= next_cp_active;
        end
    end

    // ****************************************************************
    // activity, collision and jam
    // ****************************************************************
    typedef enum logic [1:0] {RPTAC_IDLE, RPTAC_RPT, RPTAC_JAM} rptac_state_t;
    rptac_state_t state, next_state;
    logic [N-1:0] rx_ok;      // receiving and not partitioned
    logic [3:0] nrx;
    logic coll_now;
    logic [7:0] drain, next_drain;
    logic [7:0] bit_cnt, next_bit_cnt;
    logic jam_bit, next_jam_bit;
    logic next_act, next_coll, next_rpt;
    logic [N-1:0] src, next_src;  // port being repeated
    logic [N-1:0] next_tx_en, next_rx_coll, next_tx_coll;

    assign rx_ok = rx_s2 & ~partitioned;
    assign nrx = pop(rx_ok);
    // collision causes
    assign coll_now = (nrx > 4'h1)
        || ((rx_ok & ~src) != '0 && state == RPTAC_RPT)
        || cp_active;

    always_comb begin
        next_state = state;
        next_drain = drain;
        next_bit_cnt = bit_cnt;
        next_jam_bit = jam_bit;
        next_src = src;
        case (state)
            RPTAC_IDLE: begin
                if (coll_now) begin
                    next_state = RPTAC_JAM;
                end else if (nrx == 4'h1) begin
                    next_state = RPTAC_RPT;
                    next_src = rx_ok;
                end
                next_drain = 8'(rptac_pkg::DRAIN_CYC);
            end
            RPTAC_RPT: begin
                if (coll_now) begin
                    next_state = RPTAC_JAM;
                end else if ((rx_ok & src) != '0) begin
                    next_drain = 8'(rptac_pkg::DRAIN_CYC);
                end else if (drain != 8'h00) begin
                    next_drain = drain - 8'h01;
                end else begin
                    next_state = RPTAC_IDLE;
                    next_src = '0;
                end
            end
            RPTAC_JAM: begin
                // alternating pattern at the bit rate
                if (bit_cnt == 8'h00) begin
                    next_bit_cnt = 8'(rptac_pkg::JAM_BIT_CYC - 1);
                    next_jam_bit = ~jam_bit;
                end else begin
                    next_bit_cnt = bit_cnt - 8'h01;
                end
                if (nrx == 4'h0 && !cp_active) begin
                    next_state = RPTAC_IDLE;
                    next_src = '0;
                end
            end
            default: next_state = RPTAC_IDLE;
        endcase
        if (next_state != RPTAC_JAM) begin
            next_bit_cnt = 8'(rptac_pkg::JAM_BIT_CYC - 1);
            next_jam_bit = 1'b1;
        end
        // active status drives the request output
        next_act = (next_state == RPTAC_RPT)
            || (next_state == RPTAC_JAM && nrx != 4'h0);
        next_coll = (next_state == RPTAC_JAM);
        next_rpt = (next_state != RPTAC_IDLE);
        // receive collision: detector is not a colliding node
        next_rx_coll = '0;
        next_tx_coll = '0;
        if (next_coll) begin
            next_rx_coll[A] = cp_active && !port_tx_en[A];
            if (nrx == 4'h1) begin
                next_rx_coll = next_rx_coll | rx_ok;
            end
        end
        // repeat to all unpartitioned ports but the source; jam goes to all unpartitioned ports
        next_tx_en = next_coll ? ~partitioned : (next_rpt ? ~next_src & ~partitioned : '0);
        // aui in receive collision is the source: keep it silent, which holds the flag
        if (next_coll && cp_active && !port_tx_en[A]) begin
            next_tx_en[A] = 1'b0;
        end
        next_tx_coll[A] = cp_active && port_tx_en[A];
        for (int i = 0; i < rptac_pkg::TP_PORTS; i++) begin
            next_tx_coll[i] = rx_ok[i] && port_tx_en[i];
        end
    end

    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= RPTAC_IDLE;
            drain <= rptac_pkg::CNT_RST;
            bit_cnt <= rptac_pkg::CNT_RST;
            jam_bit <= 1'b1;
            src <= '0;
            act_req <= 1'b0;
            collision <= 1'b0;
            jam_data <= 1'b0;
            repeat_tx <= 1'b0;
            port_tx_en <= '0;
            rx_coll <= '0;
            tx_coll <= '0;
        end else begin
            state <= next_state;
            drain <= next_drain;
            bit_cnt <= next_bit_cnt;
            jam_bit <= next_jam_bit;
            src <= next_src;
            act_req <= next_act;
            collision <= next_coll;
            jam_data <= next_coll & next_jam_bit;
            repeat_tx <= next_rpt;
            port_tx_en <= next_tx_en;
            rx_coll <= next_rx_coll;
            tx_coll <= next_tx_coll;
        end
    end

    // ****************************************************************
    // per-port partition guards
    // ****************************************************************
    logic frame_end;
    assign frame_end = (state != RPTAC_IDLE) && (next_state == RPTAC_IDLE);
    for (genvar g = 0; g < N; g++) begin : g_guard
        logic involved;
        logic own_end; // isolated port's own reception ended without collision
        assign involved = src[g] || tx_coll[g] || rx_s2[g];
        // an isolated port never starts a repeat, so its own clean traffic counts here
        assign own_end = partitioned[g] && rx_s3[g] && !rx_s2[g] && !collision;
        rptac_port_guard #(
            .PART_LIMIT(PART_LIMIT),
            .RECONN_LIMIT(RECONN_LIMIT)
        ) u_guard (
            .core_clk(core_clk),
            .reset(reset),
            .coll_end(frame_end && collision && involved),
            .clean_end((frame_end && !collision && involved) || own_end),
            .part(partitioned[g])
        );
    end

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (reset);
    sequence two_rx_s;
        nrx > 4'h1;
    endsequence
    sequence jam_s;
        collision;
    endsequence
    multi_rx_coll_a: assert property (two_rx_s |=> jam_s)
        else $error("two receivers did not give collision");
    rpt_coll_a: assert property (state == RPTAC_RPT && (rx_ok & ~src) != '0 |=> collision)
        else $error("reception while repeating missed");
    cp_coll_a: assert property (cp_active |=> collision)
        else $error("collision presence ignored");
    jam_act_a: assert property (collision && !act_req |-> $past(nrx) == 4'h0)
        else $error("jam activity wrong");
    act_req_a: assert property (repeat_tx && !collision |-> act_req)
        else $error("repeat without activity request");
    jam_toggle_a: assert property (collision && $past(collision) && bit_cnt == 8'h00
        |=> (jam_bit != $past(jam_bit)) || !collision)
        else $error("jam not alternating");
    act_src_a: assert property (act_req |-> repeat_tx)
        else $error("activity outside repeat");
    tp_txcoll_a: assert property (rx_ok[0] && port_tx_en[0] |=> tx_coll[0])
        else $error("tp transmit collision missed");
    aui_txcoll_a: assert property (cp_active && port_tx_en[A] |=> tx_coll[A])
        else $error("aui transmit collision missed");
    part_tx_a: assert property (partitioned != '0 |-> (port_tx_en & partitioned) == '0)
        else $error("partitioned port transmitting");
endmodule

// File: testbench/rptac_station_model.sv
`timescale 1ns/1ps
// ****************************************************************
// network stations: per-port carrier and remote collision signal
// ****************************************************************
module rptac_station_model (
    input wire logic core_clk,
    input wire logic [8:0] rx_req,
    input wire logic cp_req,
    output logic [8:0] port_rx,
    output logic collision_presence_pair
);
    int half_cnt = 0; // cycles into the current half period
    // pair idles low until signalling starts
    initial collision_presence_pair = 1'h0;
    // carrier on each port follows the requesting station
    assign port_rx = rx_req;
    // square wave near 10 mhz while signalling, idle low otherwise
    always @(posedge core_clk) begin
        if (!cp_req) begin
            half_cnt <= 0;
            collision_presence_pair <= 1'h0;
        end else if (half_cnt == rptac_pkg::CP_HALF_CYC - 1) begin
            half_cnt <= 0;
            collision_presence_pair <= !collision_presence_pair;
        end else begin
            half_cnt <= half_cnt + 1;
        end
    end
endmodule

// File: testbench/repeater_activity_collision_tb.sv
`timescale 1ns/1ps
// ****************************************************************
// bench for activity, collision, jam and partition behaviour
// ****************************************************************
module repeater_activity_collision_tb;
    localparam int IDLE_CYC = 200; // outlasts drain and presence hold
    typedef struct packed {logic [8:0] rx; logic cp; logic act; logic coll;} rptac_row_t;
    logic core_clk = 1'h0;
    logic reset = 1'h1;
    logic [8:0] rx_req = 9'h000; // stations asked to send
    logic cp_req = 1'h0; // remote collision asked for
    logic [8:0] port_rx;
    logic collision_presence_pair;
    logic act_req, collision, jam_data, repeat_tx;
    logic [8:0] port_tx_en, rx_coll, tx_coll, partitioned;
    int err_total = 0;
    int checked = 0;
    // ordinary cases: senders, remote collision, expected activity and collision
    rptac_row_t rows [8] = '{
        {9'h001, 1'h0, 1'h1, 1'h0}, {9'h002, 1'h0, 1'h1, 1'h0},
        {9'h080, 1'h0, 1'h1, 1'h0}, {9'h100, 1'h0, 1'h1, 1'h0},
        {9'h003, 1'h0, 1'h1, 1'h1}, {9'h101, 1'h0, 1'h1, 1'h1},
        {9'h0f0, 1'h0, 1'h1, 1'h1}, {9'h000, 1'h1, 1'h0, 1'h1}};

    always #2 core_clk = ~core_clk;

    rptac_station_model model_u (
        .core_clk(core_clk),
        .rx_req(rx_req),
        .cp_req(cp_req),
        .port_rx(port_rx),
        .collision_presence_pair(collision_presence_pair)
    );

    rptac_core #(.PART_LIMIT(3), .RECONN_LIMIT(2)) dut_u (
        .core_clk(core_clk),
        .reset(reset),
        .port_rx(port_rx),
        .collision_presence_pair(collision_presence_pair),
        .act_req(act_req),
        .collision(collision),
        .jam_data(jam_data),
        .repeat_tx(repeat_tx),
        .port_tx_en(port_tx_en),
        .rx_coll(rx_coll),
        .tx_coll(tx_coll),
        .partitioned(partitioned)
    );

    // ****************************************************************
    // helpers
    // ****************************************************************
    // wait edges, then step just past the last one
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    task automatic chk1(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chk9(input logic [8:0] got, input logic [8:0] exp);
        checked++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one reception, then quiet long enough for the episode to close
    task automatic frame(input logic [8:0] rx, input int len);
        rx_req = rx;
        cyc(len);
        rx_req = 9'h000;
        cyc(IDLE_CYC);
    endtask
    // a clean frame from every port breaks collision runs
    task automatic sweep;
        for (int p = 0; p < 9; p++) frame(9'h001 << p, 20);
    endtask
    // find a jam edge, then sample mid-bit for six bits
    task automatic jam_check;
        logic exp;
        exp = jam_data;
        for (int k = 0; k < 60 && jam_data === exp; k++) cyc(1);
        exp = jam_data;
        cyc(rptac_pkg::JAM_BIT_CYC / 2);
        for (int k = 0; k < 6; k++) begin
            chk1(jam_data, exp);
            exp = ~exp;
            cyc(rptac_pkg::JAM_BIT_CYC);
        end
    endtask
    task automatic stop_test;
        $display("checks %0d errors %0d", checked, err_total);
        if (err_total == 0 && checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        cyc(12);
        chk1(act_req, 1'h0);
        chk9(port_tx_en, 9'h000);
        reset = 1'h0;
        cyc(2);
        chk1(collision, 1'h0);
        chk9(partitioned, 9'h000);
        // table of ordinary cases
        for (int i = 0; i < 8; i++) begin
            rx_req = rows[i].rx;
            cp_req = rows[i].cp;
            cyc(60);
            chk1(act_req, rows[i].act);
            chk1(collision, rows[i].coll);
            if (!rows[i].coll) chk9(port_tx_en, ~rows[i].rx);
            rx_req = 9'h000;
            cp_req = 1'h0;
            cyc(IDLE_CYC);
            chk1(act_req, 1'h0);
            chk1(repeat_tx, 1'h0);
        end
        sweep();
        // activity holds while buffered data drains
        rx_req = 9'h001;
        cyc(20);
        rx_req = 9'h000;
        cyc(30);
        chk1(act_req, 1'h1);
        chk1(repeat_tx, 1'h1);
        cyc(IDLE_CYC);
        // late arrival on a port being repeated to, then one port left
        rx_req = 9'h001;
        cyc(10);
        rx_req = 9'h003;
        cyc(10);
        chk1(collision, 1'h1);
        chk1(tx_coll[1], 1'h1);
        rx_req = 9'h002;
        cyc(10);
        chk1(rx_coll[1], 1'h1);
        chk1(act_req, 1'h1);
        jam_check();
        rx_req = 9'h000;
        cyc(6);
        chk1(act_req, 1'h0);
        cyc(IDLE_CYC);
        // remote collision while the aui port transmits, then while idle
        rx_req = 9'h001;
        cyc(10);
        cp_req = 1'h1;
        cyc(60);
        chk1(tx_coll[8], 1'h1);
        chk1(collision, 1'h1);
        rx_req = 9'h000;
        cp_req = 1'h0;
        cyc(IDLE_CYC);
        cp_req = 1'h1;
        cyc(60);
        chk1(rx_coll[8], 1'h1);
        chk1(port_tx_en[8], 1'h0);
        cp_req = 1'h0;
        cyc(IDLE_CYC);
        sweep();
        // three collided frames in a row isolate, two clean ones rejoin
        frame(9'h003, 20);
        frame(9'h003, 20);
        chk9(partitioned, 9'h000);
        frame(9'h003, 20);
        chk9(partitioned, 9'h003);
        frame(9'h001, 20);
        frame(9'h001, 20);
        chk1(partitioned[0], 1'h0);
        stop_test();
    end

    // watchdog well beyond the expected run length
    initial begin
        cyc(30000);
        err_total++;
        stop_test();
    end
endmodule
